// ==== design/pkseq_pkg.sv ====
// Shared constants for the power key and hard reset sequencer, both ends.
// Assumes a single 125 MHz clock on each end; times are kept in their own units.
package pkseq_pkg;
    // Clock rate and conversion base.
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned CLK_PER_MS    = CLK_HZ / MS_PER_S;

    // Documented hold times of the two request lines.
    localparam int unsigned ON_HOLD_S     = 1;
    localparam int unsigned LOWV_HOLD_S   = 3;
    localparam int unsigned OFF_HOLD_S    = 2;
    localparam int unsigned RST_HOLD_MS   = 200;

    // Delays with no printed figure: plain defaults.
    localparam int unsigned SETTLE_MS     = 100;
    localparam int unsigned BOOT_MS       = 10;
    localparam int unsigned TIMEOUT_S     = 10;

    // Derived cycle counts; all are whole multiples of the period.
    localparam int unsigned ON_HOLD_CYC   = ON_HOLD_S * CLK_HZ;
    localparam int unsigned LOWV_HOLD_CYC = LOWV_HOLD_S * CLK_HZ;
    localparam int unsigned OFF_HOLD_CYC  = OFF_HOLD_S * CLK_HZ;
    localparam int unsigned RST_HOLD_CYC  = RST_HOLD_MS * CLK_PER_MS;
    localparam int unsigned SETTLE_CYC    = SETTLE_MS * CLK_PER_MS;
    localparam int unsigned BOOT_CYC      = BOOT_MS * CLK_PER_MS;
    localparam int unsigned TIMEOUT_CYC   = TIMEOUT_S * CLK_HZ;

    // Counter width and levels of the open-collector lines.
    localparam int unsigned CNT_W         = 32;
    localparam logic        LINE_ACTIVE   = 1'b0;
    localparam logic        LINE_IDLE     = 1'b1;
    localparam logic        OE_ON         = 1'b0;
    localparam logic        OE_OFF        = 1'b1;
endpackage : pkseq_pkg

// ==== design/pkseq_link_if.sv ====
// Link between the host sequencer and the module: two open-collector
// request lines and the power-on indicator. Resolves the pulled-up wires.
`timescale 1ns/100ps
interface pkseq_link_if;
    // Host drive of the power key and hard reset lines.
    logic key_o;
    logic key_oe_n;
    logic rst_o;
    logic rst_oe_n;
    // Resolved line levels seen by the module.
    logic key_n;
    logic rst_n;
    // Module status output.
    logic power_on_indicator;

    // Lines are pulled up here in the interface; only the host pulls them low.
    assign key_n = (key_oe_n == pkseq_pkg::OE_ON) ? key_o : pkseq_pkg::LINE_IDLE;
    assign rst_n = (rst_oe_n == pkseq_pkg::OE_ON) ? rst_o : pkseq_pkg::LINE_IDLE;

    modport device (input key_n, input rst_n, output power_on_indicator);
    modport host (output key_o, output key_oe_n, output rst_o, output rst_oe_n,
                  input power_on_indicator);
endinterface : pkseq_link_if

// ==== design/pkseq_device.sv ====
// Module end: watches the power key and hard reset lines and sequences
// switch-on, detach-then-off and, from the on or detach state, restart without detach.
// Assumes the link lines are asynchronous to clk and pulled up in the interface.
`timescale 1ns/100ps
module pkseq_device #(
    parameter int unsigned ON_CYC   = pkseq_pkg::ON_HOLD_CYC,
    parameter int unsigned LOWV_CYC = pkseq_pkg::LOWV_HOLD_CYC,
    parameter int unsigned OFF_CYC  = pkseq_pkg::OFF_HOLD_CYC,
    parameter int unsigned RST_CYC  = pkseq_pkg::RST_HOLD_CYC,
    parameter int unsigned BOOT_CYC = pkseq_pkg::BOOT_CYC
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic nrst,
    // Link to the host.
    pkseq_link_if.device link,
    // Module side.
    input  wire logic supply_low,
    input  wire logic sw_off_req,
    input  wire logic detach_done,
    output logic      detach_req,
    output logic      core_run,
    output logic      restart_pulse
);
    typedef enum logic [2:0] {D_OFF, D_BOOT, D_ON, D_DETACH} pkseq_dstate_type;

    pkseq_dstate_type                 state;
    logic                             key_m, key_s, rst_m, rst_s;
    logic [pkseq_pkg::CNT_W-1:0]      key_cnt, rst_cnt, boot_cnt;
    logic                             ignore_hold;
    logic                             off_release, rst_release;

    // Two-stage synchronisers; the first stage feeds only the second.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            key_m <= pkseq_pkg::LINE_IDLE;
            key_s <= pkseq_pkg::LINE_IDLE;
            rst_m <= pkseq_pkg::LINE_IDLE;
            rst_s <= pkseq_pkg::LINE_IDLE;
        end
        else
        begin
            key_m <= link.key_n;
            key_s <= key_m;
            rst_m <= link.rst_n;
            rst_s <= rst_m;
        end
    end

    // Count low cycles of each line; the count is cleared one cycle after
    // release, so at the release cycle it still shows the whole pulse.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            key_cnt <= '0;
            rst_cnt <= '0;
        end
        else
        begin
            if (key_s == pkseq_pkg::LINE_IDLE)
                key_cnt <= '0;
            else if (key_cnt != '1)
                key_cnt <= key_cnt + 1'b1;
            if (rst_s == pkseq_pkg::LINE_IDLE)
                rst_cnt <= '0;
            else if (rst_cnt != '1)
                rst_cnt <= rst_cnt + 1'b1;
        end
    end

    // The off pulse counts only on its release, so a held key never powers
    // the module down while it is still low.
    assign off_release = (key_s == pkseq_pkg::LINE_IDLE) && !ignore_hold
                       && (key_cnt >= pkseq_pkg::CNT_W'(OFF_CYC));
    assign rst_release = (rst_s == pkseq_pkg::LINE_IDLE)
                       && (rst_cnt >= pkseq_pkg::CNT_W'(RST_CYC));

    // The press that switched the module on must not also switch it off.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ignore_hold <= 1'b0;
        else if (state == D_OFF)
            ignore_hold <= 1'b1;
        else if (key_s == pkseq_pkg::LINE_IDLE)
            ignore_hold <= 1'b0;
    end

    // Main sequence.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state         <= D_OFF;
            boot_cnt      <= '0;
            restart_pulse <= 1'b0;
        end
        else
        begin
            restart_pulse <= 1'b0;
            case (state)
                D_OFF:
                begin
                    boot_cnt <= '0;
                    // A low supply needs the longer press.
                    if (key_cnt >= pkseq_pkg::CNT_W'(supply_low ? LOWV_CYC : ON_CYC))
                        state <= D_BOOT;
                end
                D_BOOT:
                begin
                    if (boot_cnt >= pkseq_pkg::CNT_W'(BOOT_CYC - 1))
                        state <= D_ON;
                    else
                        boot_cnt <= boot_cnt + 1'b1;
                end
                D_ON:
                begin
                    if (rst_release)
                    begin
                        // Restart skips the detach entirely.
                        state         <= D_BOOT;
                        boot_cnt      <= '0;
                        restart_pulse <= 1'b1;
                    end
                    else if (off_release || sw_off_req)
                        state <= D_DETACH;
                end
                D_DETACH:
                begin
                    if (rst_release)
                    begin
                        state         <= D_BOOT;
                        boot_cnt      <= '0;
                        restart_pulse <= 1'b1;
                    end
                    else if (detach_done)
                        state <= D_OFF;
                end
                default:
                    state <= D_OFF;
            endcase
        end
    end

    // Indicator is high only once fully on, low again when off or rebooting.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            link.power_on_indicator <= 1'b0;
        else
            link.power_on_indicator <= (state == D_ON) || (state == D_DETACH);
    end

    // Detach request stands until the network side confirms it or a restart ends the detach state.
    assign detach_req = (state == D_DETACH);
    assign core_run   = (state != D_OFF);
endmodule : pkseq_device

// ==== design/pkseq_host.sv ====
// Host end: turns one-cycle user commands into timed open-collector pulses
// on the power key and hard reset lines and tracks the module's indicator.
// Assumes the indicator is asynchronous to clk and the lines are pulled up.
`timescale 1ns/100ps
module pkseq_host #(
    parameter int unsigned ON_CYC      = pkseq_pkg::ON_HOLD_CYC,
    parameter int unsigned LOWV_CYC    = pkseq_pkg::LOWV_HOLD_CYC,
    parameter int unsigned OFF_CYC     = pkseq_pkg::OFF_HOLD_CYC,
    parameter int unsigned RST_CYC     = pkseq_pkg::RST_HOLD_CYC,
    parameter int unsigned SETTLE_CYC  = pkseq_pkg::SETTLE_CYC,
    parameter int unsigned TIMEOUT_CYC = pkseq_pkg::TIMEOUT_CYC
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic nrst,
    // Link to the module.
    pkseq_link_if.host link,
    // User commands, one-cycle pulses, and the low-supply level.
    input  wire logic cmd_on,
    input  wire logic cmd_off,
    input  wire logic cmd_reset,
    input  wire logic supply_low,
    // User status.
    output logic      busy,
    output logic      powered,
    output logic      done,
    output logic      timeout_err,
    output logic      refused,
    output logic      inputs_allowed
);
    typedef enum logic [2:0] {
        H_IDLE,
        H_KEY,
        H_RST,
        H_WAIT_UP,
        H_WAIT_DOWN,
        H_SETTLE
    } pkseq_hstate_type;

    pkseq_hstate_type                 state;
    logic [pkseq_pkg::CNT_W-1:0]      pulse_cnt, pulse_len, wait_cnt;
    logic                             mon_m, mon_s, mon_d;
    logic                             mon_rise, mon_fall;
    logic                             key_is_off;
    logic                             any_cmd;

    // Two-stage synchroniser on the indicator, then a delay for edges.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mon_m <= 1'b0;
            mon_s <= 1'b0;
            mon_d <= 1'b0;
        end
        else
        begin
            mon_m <= link.power_on_indicator;
            mon_s <= mon_m;
            mon_d <= mon_s;
        end
    end

    // Indicator edges; mon_d resets to the idle level, so no false rise follows reset.
    assign mon_rise = mon_s && !mon_d;
    assign mon_fall = !mon_s && mon_d;
    assign any_cmd  = cmd_on || cmd_off || cmd_reset;

    // Commands are taken only in idle; anything else is reported and dropped.
    assign busy = (state != H_IDLE);

    // Sequencing of commands, pulses and waits.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state       <= H_IDLE;
            pulse_len   <= '0;
            key_is_off  <= 1'b0;
            done        <= 1'b0;
            timeout_err <= 1'b0;
            refused     <= 1'b0;
        end
        else
        begin
            done        <= 1'b0;
            timeout_err <= 1'b0;
            refused     <= 1'b0;
            case (state)
                H_IDLE:
                begin
                    // Reset has priority: it is the emergency exit.
                    if (cmd_reset)
                    begin
                        state     <= H_RST;
                        pulse_len <= pkseq_pkg::CNT_W'(RST_CYC);
                    end
                    else if (cmd_off)
                    begin
                        state      <= H_KEY;
                        key_is_off <= 1'b1;
                        pulse_len  <= pkseq_pkg::CNT_W'(OFF_CYC);
                    end
                    else if (cmd_on)
                    begin
                        state      <= H_KEY;
                        key_is_off <= 1'b0;
                        // The low-supply figure replaces the normal one.
                        pulse_len  <= pkseq_pkg::CNT_W'(supply_low ? LOWV_CYC
                                                                   : ON_CYC);
                    end
                end
                H_KEY:
                begin
                    // Release, then await the indicator edge; the module
                    // itself detaches before it lets the indicator fall.
                    if (pulse_cnt >= pulse_len - 1'b1)
                        state <= key_is_off ? H_WAIT_DOWN : H_WAIT_UP;
                end
                H_RST:
                begin
                    // No detach follows a restart; wait for the reboot.
                    if (pulse_cnt >= pulse_len - 1'b1)
                        state <= H_WAIT_UP;
                end
                H_WAIT_UP:
                begin
                    if (mon_rise)
                        state <= H_SETTLE;
                    else if (wait_cnt >= pkseq_pkg::CNT_W'(TIMEOUT_CYC - 1))
                    begin
                        state       <= H_IDLE;
                        timeout_err <= 1'b1;
                    end
                end
                H_SETTLE:
                begin
                    if (!mon_s)
                    begin
                        state       <= H_IDLE;
                        timeout_err <= 1'b1;
                    end
                    else if (wait_cnt >= pkseq_pkg::CNT_W'(SETTLE_CYC - 1))
                    begin
                        state <= H_IDLE;
                        done  <= 1'b1;
                    end
                end
                H_WAIT_DOWN:
                begin
                    if (mon_fall)
                    begin
                        state <= H_IDLE;
                        done  <= 1'b1;
                    end
                    else if (wait_cnt >= pkseq_pkg::CNT_W'(TIMEOUT_CYC - 1))
                    begin
                        state       <= H_IDLE;
                        timeout_err <= 1'b1;
                    end
                end
                default:
                    state <= H_IDLE;
            endcase
            if (state != H_IDLE && any_cmd)
                refused <= 1'b1;
        end
    end

    // Pulse length counter, running only while a line is held low.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pulse_cnt <= '0;
        else if (state == H_KEY || state == H_RST)
            pulse_cnt <= pulse_cnt + 1'b1;
        else
            pulse_cnt <= '0;
    end

    // Wait counter for timeouts and the settle delay; restarts on each state.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wait_cnt <= '0;
        else if ((state == H_WAIT_UP && mon_rise) || state == H_IDLE
                 || state == H_KEY || state == H_RST)
            wait_cnt <= '0;
        else
            wait_cnt <= wait_cnt + 1'b1;
    end

    // The module counts as on only after the settle delay has passed.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            powered <= 1'b0;
        else if (!mon_s)
            powered <= 1'b0;
        else if (state == H_SETTLE && wait_cnt >= pkseq_pkg::CNT_W'(SETTLE_CYC - 1))
            powered <= 1'b1;
    end

    // Other host outputs toward the module must stay low while it is off.
    assign inputs_allowed = powered;

    // Open-collector drive: only ever pull low, never drive high, so no
    // high level reaches the module's pins while it is off.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            link.key_o    <= pkseq_pkg::LINE_ACTIVE;
            link.key_oe_n <= pkseq_pkg::OE_OFF;
            link.rst_o    <= pkseq_pkg::LINE_ACTIVE;
            link.rst_oe_n <= pkseq_pkg::OE_OFF;
        end
        else
        begin
            link.key_o    <= pkseq_pkg::LINE_ACTIVE;
            link.rst_o    <= pkseq_pkg::LINE_ACTIVE;
            link.key_oe_n <= (state == H_KEY) ? pkseq_pkg::OE_ON : pkseq_pkg::OE_OFF;
            link.rst_oe_n <= (state == H_RST) ? pkseq_pkg::OE_ON : pkseq_pkg::OE_OFF;
        end
    end
endmodule : pkseq_host

// ==== verification/pkseq_sva.sv ====
// Checker for the power key and hard reset link between the two ends.
// Assumes one clock and the asynchronous active-low reset shared by both ends.
`timescale 1ns/100ps
module pkseq_sva #(
    parameter int unsigned ON_CYC   = pkseq_pkg::ON_HOLD_CYC,
    parameter int unsigned LOWV_CYC = pkseq_pkg::LOWV_HOLD_CYC,
    parameter int unsigned OFF_CYC  = pkseq_pkg::OFF_HOLD_CYC,
    parameter int unsigned RST_CYC  = pkseq_pkg::RST_HOLD_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Link signals.
    input wire logic key_o,
    input wire logic key_oe_n,
    input wire logic rst_o,
    input wire logic rst_oe_n,
    input wire logic key_n,
    input wire logic rst_n,
    input wire logic power_on_indicator
);
    logic [pkseq_pkg::CNT_W-1:0] key_cnt;
    logic [pkseq_pkg::CNT_W-1:0] rst_cnt;
    logic                        ind_at_press;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // Run lengths of both pulls, read back at the edge that sees the release.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            key_cnt <= '0;
            rst_cnt <= '0;
        end
        else
        begin
            key_cnt <= (key_oe_n == pkseq_pkg::OE_ON) ? key_cnt + 1'b1 : '0;
            rst_cnt <= (rst_oe_n == pkseq_pkg::OE_ON) ? rst_cnt + 1'b1 : '0;
        end
    end

    // The indicator at the start of a press tells an on press from an off press.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ind_at_press <= 1'b0;
        else if (key_oe_n == pkseq_pkg::OE_ON && key_cnt == '0)
            ind_at_press <= power_on_indicator;
    end

    // A restart shows the indicator drop and come back.
    sequence reboot_s;
        !power_on_indicator ##[1:12] power_on_indicator;
    endsequence

    key_pull_low_a: assert property (key_oe_n == pkseq_pkg::OE_ON |-> key_o == 1'b0)
        else $error("key line driven high");
    rst_pull_low_a: assert property (rst_oe_n == pkseq_pkg::OE_ON |-> rst_o == 1'b0)
        else $error("reset line driven high");
    key_pulse_len_a: assert property ($rose(key_oe_n) |-> (ind_at_press ?
        key_cnt == OFF_CYC : (key_cnt == ON_CYC || key_cnt == LOWV_CYC)))
        else $error("key pulse length wrong");
    rst_pulse_len_a: assert property ($rose(rst_oe_n) |-> rst_cnt == RST_CYC)
        else $error("reset pulse length wrong");
    one_request_a: assert property (!(key_oe_n == 1'b0 && rst_oe_n == 1'b0))
        else $error("both lines pulled at once");
    key_rest_a: assert property ($rose(key_oe_n) |=> key_oe_n [*3])
        else $error("key pulled again at once");
    held_no_off_a: assert property (key_n == 1'b0 && power_on_indicator
        |=> power_on_indicator)
        else $error("shutdown while key held");
    restart_cycle_a: assert property ($rose(rst_oe_n) && power_on_indicator
        |-> ##[1:8] reboot_s)
        else $error("restart did not cycle the indicator");
endmodule : pkseq_sva

// ==== verification/module_power_key_reset_sequencer_tb.sv ====
// Bench joining host and module ends through the link interface.
// Assumes shortened pulse parameters; runs well under the cycle ceiling.
`timescale 1ns/100ps
module module_power_key_reset_sequencer_tb;
    localparam int unsigned ON = 20, LOWV = 60, OFF = 40, RST = 8, SET = 5, TMO = 200, BOOT = 4;
    logic        clk, nrst, cmd_on, cmd_off, cmd_reset, supply_low, sw_off_req, detach_done;
    logic        busy, powered, done, timeout_err, refused, inputs_allowed;
    logic        detach_req, core_run, restart_pulse;
    logic [31:0] seed = 32'h028A1905;
    logic [2:0]  q[$];
    int          lq[$];
    int          n_fail = 0, checks = 0, cyc = 0, run = 0, n_det = 0, n_rst = 0, d0, r0;

    pkseq_link_if link();
    pkseq_host #(.ON_CYC(ON), .LOWV_CYC(LOWV), .OFF_CYC(OFF), .RST_CYC(RST),
        .SETTLE_CYC(SET), .TIMEOUT_CYC(TMO)) i_pkseq_host (.clk(clk), .nrst(nrst),
        .link(link), .cmd_on(cmd_on), .cmd_off(cmd_off), .cmd_reset(cmd_reset),
        .supply_low(supply_low), .busy(busy), .powered(powered), .done(done),
        .timeout_err(timeout_err), .refused(refused), .inputs_allowed(inputs_allowed));
    pkseq_device #(.ON_CYC(ON), .LOWV_CYC(LOWV), .OFF_CYC(OFF), .RST_CYC(RST),
        .BOOT_CYC(BOOT)) i_pkseq_device (.clk(clk), .nrst(nrst), .link(link),
        .supply_low(supply_low), .sw_off_req(sw_off_req), .detach_done(detach_done),
        .detach_req(detach_req), .core_run(core_run), .restart_pulse(restart_pulse));
    pkseq_sva #(.ON_CYC(ON), .LOWV_CYC(LOWV), .OFF_CYC(OFF), .RST_CYC(RST)) i_pkseq_sva (
        .clk(clk), .nrst(nrst), .key_o(link.key_o), .key_oe_n(link.key_oe_n),
        .rst_o(link.rst_o), .rst_oe_n(link.rst_oe_n), .key_n(link.key_n),
        .rst_n(link.rst_n), .power_on_indicator(link.power_on_indicator));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    // Issue one command, note the expected pulse and result, wait for idle.
    task automatic cmd(input int k, input int len, input logic [2:0] note, input bit poke);
        int n;
        lq.push_back(len);
        q.push_back(note);
        @(negedge clk);
        // Kind 3 raises reset and on together; the reset pulse must win.
        cmd_on <= (k == 0) || (k == 3);
        cmd_off <= (k == 1);
        cmd_reset <= (k >= 2);
        @(negedge clk);
        cmd_on <= 1'b0;
        cmd_reset <= 1'b0;
        cmd_off <= poke;
        if (poke)
        begin
            @(negedge clk);
            cmd_off <= 1'b0;
            check("refused", {31'h0, refused}, 32'h1);
        end
        n = 0;
        while (busy !== 1'b0 && n < 600)
        begin
            @(negedge clk);
            n++;
        end
        check("busy", {31'h0, busy}, 32'h0);
        repeat (xs(seed) % 8 + 2) @(negedge clk);
        seed = xs(seed);
    endtask : cmd

    // Clock at 125 MHz.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard; the tests need a few thousand cycles at most.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    // Each done or timeout takes the oldest noted result.
    always @(negedge clk)
        if (done === 1'b1 || timeout_err === 1'b1)
            check("status", {29'h0, timeout_err, powered, link.power_on_indicator},
                {29'h0, q.pop_front()});

    // Each pull run on either line takes the oldest noted length; restarts are counted.
    always @(negedge clk)
    begin
        if (restart_pulse === 1'b1)
            n_rst++;
        if (link.key_oe_n === 1'b0 || link.rst_oe_n === 1'b0)
            run++;
        else if (run > 0)
        begin
            check("pulse length", 32'(run), 32'(lq.pop_front()));
            run = 0;
        end
    end

    // The network side answers a detach after a random delay.
    initial
    begin
        detach_done = 1'b0;
        forever
        begin
            @(negedge clk);
            if (detach_req === 1'b1)
            begin
                n_det++;
                check("key released", {31'h0, link.key_n}, 32'h1);
                check("on in detach", {31'h0, link.power_on_indicator}, 32'h1);
                repeat (xs(seed) % 8 + 1) @(negedge clk);
                seed = xs(seed);
                detach_done <= 1'b1;
                @(negedge clk);
                detach_done <= 1'b0;
            end
        end
    end

    // Main sequence.
    initial
    begin
        {cmd_on, cmd_off, cmd_reset, supply_low, sw_off_req} = 5'h00;
        nrst = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        cmd(0, ON, 3'h3, 1'b1);
        check("inputs allowed on", {31'h0, inputs_allowed}, 32'h1);
        check("core runs", {31'h0, core_run}, 32'h1);
        $display("test switch on done");
        cmd(1, OFF, 3'h0, 1'b0);
        check("detach count", 32'(n_det), 32'h1);
        check("inputs allowed off", {31'h0, inputs_allowed}, 32'h0);
        $display("test key off done");
        supply_low = 1'b1;
        cmd(0, LOWV, 3'h3, 1'b0);
        supply_low = 1'b0;
        $display("test low supply on done");
        d0 = n_det;
        r0 = n_rst;
        cmd(3, RST, 3'h3, 1'b0);
        repeat (20) @(negedge clk);
        check("restart pulse", 32'(n_rst - r0), 32'h1);
        check("no detach", 32'(n_det - d0), 32'h0);
        check("on after restart", {31'h0, link.power_on_indicator}, 32'h1);
        $display("test restart done");
        sw_off_req <= 1'b1;
        @(negedge clk);
        sw_off_req <= 1'b0;
        repeat (30) @(negedge clk);
        check("sw detach", 32'(n_det - d0), 32'h1);
        check("sw off", {30'h0, link.power_on_indicator, core_run}, 32'h0);
        $display("test software off done");
        cmd(2, RST, 3'h4, 1'b0);
        check("notes left", 32'(q.size() + lq.size()), 32'h0);
        $display("test restart while off done");
        give_verdict();
    end
endmodule : module_power_key_reset_sequencer_tb
